// *** asr_pkg.sv ***
// Package of widths, timing figures and states for the asynchronous static memory controller.
package asr_pkg;

  // Memory organisation.
  localparam int ASR_ADDR_W = 13;
  localparam int ASR_DATA_W = 8;
  localparam int ASR_WORDS  = 8192;

  // Controller clock period.
  localparam int CLK_PERIOD_NS = 50;

  // Memory timing in nanoseconds, slower grade, which also covers the faster grade.
  localparam int T_RC_NS  = 100;
  localparam int T_AA_NS  = 100;
  localparam int T_OE_NS  = 50;
  localparam int T_OHZ_NS = 35;
  localparam int T_WC_NS  = 100;
  localparam int T_CW_NS  = 80;
  localparam int T_AW_NS  = 80;
  localparam int T_WP_NS  = 60;
  localparam int T_WHZ_NS = 35;
  localparam int T_DW_NS  = 40;

  // A least time rounds up to whole cycles and never gives less than one.
  function automatic int asr_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int asr_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Derived cycle counts.
  localparam int RC_CYC    = asr_cyc(T_RC_NS);
  localparam int WHZ_CYC   = asr_cyc(T_WHZ_NS);
  localparam int OHZ_CYC   = asr_cyc(T_OHZ_NS);
  localparam int WP_CYC    = asr_max(asr_max(asr_cyc(T_WP_NS), asr_cyc(T_WHZ_NS + T_DW_NS)),
                                     WHZ_CYC + asr_cyc(T_DW_NS));
  localparam int SETUP_CYC = asr_max(OHZ_CYC, asr_max(asr_cyc(T_CW_NS), asr_cyc(T_AW_NS))
                                     - WP_CYC);
  localparam int HOLD_CYC  = asr_max(1, asr_cyc(T_WC_NS) - SETUP_CYC - WP_CYC);
  localparam int RD_CYC    = asr_max(RC_CYC, asr_max(asr_cyc(T_AA_NS), asr_cyc(T_OE_NS)));
  localparam int SYNC_LAT  = 4;
  // One spare cycle, because the access time runs out exactly on a clock edge and the
  // first stage may not yet see the word at that edge.
  localparam int RD_MARGIN = 1;
  localparam int CAP_CYC   = RD_CYC + SYNC_LAT + RD_MARGIN;

  // Width of the phase timer.
  localparam int CNT_W = 4;

  // Reset values of the pins.
  localparam logic [ASR_DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ASR_ADDR_W-1:0] ADDR_RST = 13'h0000;

  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_RETAIN,
    ASR_RECOVER,
    ASR_W_SETUP,
    ASR_W_PULSE,
    ASR_W_HOLD,
    ASR_R_ACCESS,
    ASR_R_RELEASE
  } asr_state_t;

endpackage

// *** asr_sync_if.sv ***
// Interface carrying the raw data pins and their filtered value between controller modules.
`timescale 1ns/100ps
interface asr_sync_if #(
  parameter int W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] stable;

  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// *** asr_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for the data pins.
`timescale 1ns/100ps
module asr_pin_sync import asr_pkg::*; #(
  parameter int W = ASR_DATA_W
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  asr_sync_if.sync  port
);

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      // The first stage feeds only the second, so metastability cannot reach the filter.
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          s1   <= 1'b0;
          s2   <= 1'b0;
          s3   <= 1'b0;
          filt <= 1'b0;
        end else begin
          s1 <= port.raw[b];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt <= s3;
          end
        end
      end
      assign port.stable[b] = filt;
    end
  endgenerate

endmodule // asr_pin_sync

// *** asr_host.sv ***
// Controller that drives an asynchronous static memory through its pins.
//
// Behaviour
// - Write strobe stays low long enough.
// - Selects asserted long enough before write end.
// - Address stable before write, valid long enough.
// - Address held past write end; cycle long.
// - Write data set up and held.
// - No opposing drive while memory releases.
// - Strobe covers release plus data overlap.
// - High select held firm during retention.
`timescale 1ns/100ps
module asr_host import asr_pkg::*; #(
  parameter int AW = ASR_ADDR_W,
  parameter int DW = ASR_DATA_W
) (
  input  wire logic          mclk_i,
  input  wire logic          reset_i,
  input  wire logic          req_i,
  input  wire logic          write_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          retain_i,
  output wire logic          ready_o,
  output logic      [DW-1:0] rdata_o,
  output logic               rvalid_o,
  output logic               retained_o,
  output logic      [AW-1:0] addr_in_o,
  output logic               select_low_active_o,
  output logic               select_high_active_o,
  output logic               write_strobe_n_o,
  output logic               drive_enable_n_o,
  input  wire logic [DW-1:0] bidir_data_bus_i,
  output logic      [DW-1:0] bidir_data_bus_o,
  output logic               bidir_data_bus_oe_o
);

  asr_state_t         state;
  asr_state_t         next_state;
  logic   [CNT_W-1:0] cnt;
  logic   [CNT_W-1:0] next_cnt;
  logic      [DW-1:0] wdata_q;
  logic               timer_done;
  logic               take_req;

  asr_sync_if #(.W(DW)) sync_bus ();

  // Read data comes from another timing domain, so it passes the filtered synchroniser.
  assign sync_bus.raw = bidir_data_bus_i;

  asr_pin_sync #(.W(DW)) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .port    (sync_bus)
  );

  // Handshake decode; retention has priority over a new request.
  // A refused request is dropped, not queued, so the caller holds it until ready_o.
  assign timer_done = (cnt == '0);
  assign ready_o    = (state == ASR_IDLE) && !retain_i;
  assign take_req   = ready_o && req_i;

  // Phase sequencer; every phase lasts its loaded count plus one cycle.
  always_comb begin
    next_state = state;
    next_cnt   = (cnt == '0) ? cnt : cnt - 1'b1;
    case (state)
      ASR_IDLE: begin
        // The address pin loads on this same edge, so setup starts with a valid address.
        if (retain_i) begin
          next_state = ASR_RETAIN;
        end else if (take_req && write_i) begin
          next_state = ASR_W_SETUP;
          next_cnt   = CNT_W'(SETUP_CYC - 1);
        end else if (take_req) begin
          next_state = ASR_R_ACCESS;
          next_cnt   = CNT_W'(CAP_CYC - 1);
        end
      end
      ASR_RETAIN: begin
        // Leaving retention waits a full read cycle while the supply settles.
        if (!retain_i) begin
          next_state = ASR_RECOVER;
          next_cnt   = CNT_W'(RC_CYC - 1);
        end
      end
      ASR_RECOVER: begin
        if (timer_done) begin
          next_state = ASR_IDLE;
        end
      end
      ASR_W_SETUP: begin
        if (timer_done) begin
          next_state = ASR_W_PULSE;
          next_cnt   = CNT_W'(WP_CYC - 1);
        end
      end
      ASR_W_PULSE: begin
        if (timer_done) begin
          next_state = ASR_W_HOLD;
          next_cnt   = CNT_W'(HOLD_CYC - 1);
        end
      end
      ASR_W_HOLD: begin
        if (timer_done) begin
          next_state = ASR_IDLE;
        end
      end
      ASR_R_ACCESS: begin
        if (timer_done) begin
          next_state = ASR_R_RELEASE;
          next_cnt   = CNT_W'(OHZ_CYC - 1);
        end
      end
      ASR_R_RELEASE: begin
        if (timer_done) begin
          next_state = ASR_IDLE;
        end
      end
      default: begin
        next_state = ASR_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // Pin levels for the coming cycle, decoded from the next phase.
  // Deselecting between accesses keeps the memory in power-down whenever we are idle.
  logic next_sel;
  logic next_sel_high;
  logic next_we_n;
  logic next_oe_n;
  logic next_drive;

  // Selects stay asserted from setup through hold so chip select time covers the write.
  assign next_sel      = (next_state == ASR_W_SETUP) || (next_state == ASR_W_PULSE) ||
                         (next_state == ASR_W_HOLD) || (next_state == ASR_R_ACCESS);
  // During retention the high select is driven firmly low, never left floating.
  assign next_sel_high = next_sel;
  assign next_we_n     = !(next_state == ASR_W_PULSE);
  // Output enable stays high for the whole write so the memory never fights our data.
  assign next_oe_n     = !(next_state == ASR_R_ACCESS);
  // Data starts only after the memory's release time from the strobe edge and stays
  // one cycle past the strobe rise for the zero hold.
  assign next_drive    = ((next_state == ASR_W_PULSE) &&
                          (next_cnt < CNT_W'(WP_CYC - WHZ_CYC))) ||
                         (next_state == ASR_W_HOLD);

  // State, timer and the latched request.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state   <= ASR_IDLE;
      cnt     <= '0;
      wdata_q <= DATA_RST;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take_req) begin
        wdata_q <= wdata_i;
      end
    end
  end

  // Registered pins; the address changes only in idle, never inside a write.
  // Every pin leaves a flip-flop, so no decode glitch ever reaches the memory.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_in_o            <= ADDR_RST;
      select_low_active_o  <= 1'b1;
      select_high_active_o <= 1'b0;
      write_strobe_n_o     <= 1'b1;
      drive_enable_n_o     <= 1'b1;
      bidir_data_bus_o     <= DATA_RST;
      bidir_data_bus_oe_o  <= 1'b0;
    end else begin
      if (take_req) begin
        addr_in_o <= addr_i;
      end
      select_low_active_o  <= !next_sel;
      select_high_active_o <= next_sel_high;
      write_strobe_n_o     <= next_we_n;
      drive_enable_n_o     <= next_oe_n;
      bidir_data_bus_o     <= wdata_q;
      bidir_data_bus_oe_o  <= next_drive;
    end
  end

  // Read capture happens once the access time and the synchroniser latency have passed.
  // The margin cycle costs one cycle per read, but a word that settles right on a clock
  // edge is never taken while it is still half-way through the filter.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o    <= DATA_RST;
      rvalid_o   <= 1'b0;
      retained_o <= 1'b0;
    end else begin
      rvalid_o   <= 1'b0;
      retained_o <= (next_state == ASR_RETAIN);
      if ((state == ASR_R_ACCESS) && timer_done) begin
        rdata_o  <= sync_bus.stable;
        rvalid_o <= 1'b1;
      end
    end
  end

endmodule // asr_host

// *** asr_host_asserts.sv ***
// Pin timing assertions for the static memory controller.
`timescale 1ns/100ps
module asr_host_asserts import asr_pkg::*; #(
  parameter int AW = ASR_ADDR_W,
  parameter int DW = ASR_DATA_W
) (
  input wire logic          mclk_i,
  input wire logic          reset_i,
  input wire logic          req_i,
  input wire logic          write_i,
  input wire logic          ready_o,
  input wire logic          rvalid_o,
  input wire logic          retained_o,
  input wire logic [AW-1:0] addr_in_o,
  input wire logic          select_low_active_o,
  input wire logic          select_high_active_o,
  input wire logic          write_strobe_n_o,
  input wire logic          drive_enable_n_o,
  input wire logic          bidir_data_bus_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Request taken and both selects active.
  wire take = req_i && ready_o;
  wire sel  = !select_low_active_o && select_high_active_o;
  // Write: one setup cycle, two strobe cycles, one hold cycle.
  sequence s_strobe; write_strobe_n_o ##1 !write_strobe_n_o [*2] ##1 write_strobe_n_o; endsequence
  sequence s_wsel; sel [*4] ##1 !sel; endsequence
  // Read: output enable low through access, synchroniser latency and margin cycle.
  sequence s_rd; (sel && !drive_enable_n_o && write_strobe_n_o) [*7] ##1 drive_enable_n_o; endsequence
  a_write_strobe: assert property (take && write_i |=> s_strobe)
    else $error("Write strobe shape wrong.");
  a_write_sel: assert property (take && write_i |=> s_wsel)
    else $error("Selects not held over write.");
  a_strobe_quiet: assert property ($fell(write_strobe_n_o) |-> !bidir_data_bus_oe_o)
    else $error("Data driven as strobe falls.");
  a_one_driver: assert property (bidir_data_bus_oe_o |-> drive_enable_n_o && sel)
    else $error("Bus driven while memory may drive.");
  a_addr_hold: assert property ($changed(addr_in_o) |-> $past(take))
    else $error("Address moved without request.");
  a_read_walk: assert property (take && !write_i |=> s_rd)
    else $error("Read pin walk wrong.");
  a_read_answer: assert property (take && !write_i |=> !rvalid_o [*7] ##1 rvalid_o ##1 !rvalid_o)
    else $error("Read answer timing wrong.");
  a_retain_sel: assert property (retained_o |-> !select_high_active_o)
    else $error("High select not low in retention.");
  a_recover_wait: assert property ($fell(retained_o) |-> !ready_o [*2])
    else $error("Recovery wait too short.");
endmodule // asr_host_asserts

bind asr_host asr_host_asserts #(.AW(AW), .DW(DW)) i_asr_host_asserts (
  .mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i), .write_i(write_i), .ready_o(ready_o),
  .rvalid_o(rvalid_o), .retained_o(retained_o), .addr_in_o(addr_in_o),
  .select_low_active_o(select_low_active_o), .select_high_active_o(select_high_active_o),
  .write_strobe_n_o(write_strobe_n_o), .drive_enable_n_o(drive_enable_n_o),
  .bidir_data_bus_oe_o(bidir_data_bus_oe_o));

// *** asr_mem_model.sv ***
// Behavioural model of the static memory seen from its pins.
`timescale 1ns/100ps
module asr_mem_model import asr_pkg::*; #(
  parameter int ACC_NS = T_AA_NS
) (
  input  wire logic [ASR_ADDR_W-1:0] addr_i,
  input  wire logic                  select_low_active_i,
  input  wire logic                  select_high_active_i,
  input  wire logic                  write_strobe_n_i,
  input  wire logic                  drive_enable_n_i,
  input  wire logic [ASR_DATA_W-1:0] data_i,
  output wire logic [ASR_DATA_W-1:0] data_o,
  output wire logic                  data_oe_o
);
  // Static array; selects alone never disturb it.
  logic [ASR_DATA_W-1:0] mem [ASR_WORDS];
  wire sel = !select_low_active_i && select_high_active_i;
  wire wr  = sel && !write_strobe_n_i;
  wire rd  = sel && write_strobe_n_i && !drive_enable_n_i;
  // The word is stored as the overlap ends.
  always @(negedge wr) begin
    mem[addr_i] <= data_i;
  end
  // Inertial delays hold the old word and start driving late.
  assign #(ACC_NS) data_o = mem[addr_i];
  assign #10 data_oe_o = rd;
endmodule // asr_mem_model

// *** tb.sv ***
// Self-checking bench for the static memory controller.
`timescale 1ns/100ps
module tb import asr_pkg::*;;
  logic mclk_i = 1'b0, reset_i, req_i, write_i, retain_i;
  logic ready_o, rvalid_o, retained_o, csl, csh, we_n, oe_n, hoe, moe;
  logic [12:0] addr_i, a, pa, ain;
  logic [7:0] wdata_i, d, rdata_o, hd, md, bus, last_bus = 8'h5A;
  logic [7:0] shadow [ASR_WORDS];
  logic [31:0] seed;
  int err_count = 0, compares = 0, i;
  always #25 mclk_i = ~mclk_i;
  asr_host i_asr_host (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i), .write_i(write_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .retain_i(retain_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .retained_o(retained_o), .addr_in_o(ain),
    .select_low_active_o(csl), .select_high_active_o(csh), .write_strobe_n_o(we_n),
    .drive_enable_n_o(oe_n), .bidir_data_bus_i(bus), .bidir_data_bus_o(hd),
    .bidir_data_bus_oe_o(hoe));
  asr_mem_model i_asr_mem_model (.addr_i(ain), .select_low_active_i(csl),
    .select_high_active_i(csh), .write_strobe_n_i(we_n), .drive_enable_n_i(oe_n),
    .data_i(bus), .data_o(md), .data_oe_o(moe));
  // A released bus shows the inverse of its last level, so stale data cannot pass.
  always_comb bus = hoe ? hd : (moe ? md : ~last_bus);
  always @(posedge mclk_i) last_bus <= bus;
  always @(negedge mclk_i) if (!reset_i) check_bit("contention", 1'b0, hoe && moe);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [12:0] adr);
    return shadow[adr];
  endfunction
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request at a falling edge; reads wait for the answer under a bound.
  task automatic op(input logic w, input logic [12:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    req_i = 1'b1;
    write_i = w;
    addr_i = adr;
    wdata_i = dat;
    @(negedge mclk_i);
    req_i = 1'b0;
    if (w)
      shadow[adr] = dat;
    while (!w && rvalid_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      print_verdict();
    end
    if (!w)
      check8("rdata", exp_rd(adr), rdata_o);
  endtask
  initial begin
    reset_i = 1'b1;
    req_i = 1'b0;
    write_i = 1'b0;
    retain_i = 1'b0;
    addr_i = 13'h0000;
    wdata_i = 8'h00;
    seed = 32'h583F6AFF;
    pa = 13'h0000;
    repeat (10) @(negedge mclk_i);
    reset_i = 1'b0;
    op(1'b1, 13'h0000, 8'hFF);
    op(1'b1, 13'h1FFF, 8'h00);
    op(1'b0, 13'h0000, 8'h00);
    op(1'b0, 13'h1FFF, 8'h00);
    $display("test corners done");
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      a = seed[12:0];
      d = seed[28:21];
      op(1'b1, a, d);
      op(1'b0, pa, d);
      op(1'b0, a, d);
      pa = a;
    end
    $display("test random done");
    // A write asked for during retention must be refused.
    retain_i = 1'b1;
    req_i = 1'b1;
    write_i = 1'b1;
    wdata_i = ~exp_rd(a);
    repeat (20) @(negedge mclk_i);
    check_bit("retained", 1'b1, retained_o);
    req_i = 1'b0;
    retain_i = 1'b0;
    @(negedge mclk_i);
    check_bit("ready", 1'b0, ready_o);
    op(1'b0, a, d);
    $display("test retention done");
    reset_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    reset_i = 1'b0;
    check8("rdata", 8'h00, rdata_o);
    op(1'b0, pa, d);
    $display("test reset done");
    print_verdict();
  end
endmodule // tb
